// ===== hdl/urs_switch_matrix.sv
`default_nettype none
module urs_switch_matrix #(
	parameter int unsigned P_TRIM_LONG_CYC = 32'(urs_pkg::URS_TRIM_LONG_CYC), // 500 ms
	parameter int unsigned P_TRIM_SHORT_CYC = 32'(urs_pkg::URS_TRIM_SHORT_CYC) // 300 ms
) (
	input wire logic i_clk, // 25 MHz clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [11:0] i_paddr, // APB address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error
	input wire logic i_cmd_valid, // Companion unit command valid
	input wire logic [urs_pkg::URS_CMD_W-1:0] i_cmd_data, // Companion unit command
	output logic o_cmd_ready, // Command buffer ready
	input wire logic i_dut_power, // Tested-device supply present pin
	input wire logic [urs_pkg::URS_NUM_CH-1:0] i_host_tx, // Bridge transmit pins
	output logic [urs_pkg::URS_NUM_CH-1:0] o_host_rx, // Bridge receive pins
	input wire logic [urs_pkg::URS_NUM_CH-1:0] i_dut_tx, // Tested device transmit pins
	output logic [urs_pkg::URS_NUM_CH-1:0] o_dut_rx, // Tested device receive pin level
	output logic [urs_pkg::URS_NUM_CH-1:0] o_dut_rx_oe_n // Receive pin enable, low drives
);
	import urs_pkg::*;
	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [1:0] pwr_sync_reg;
	logic [URS_NUM_CH-1:0] htx_meta_reg;
	logic [URS_NUM_CH-1:0] htx_s_reg;
	logic [URS_NUM_CH-1:0] dtx_meta_reg;
	logic [URS_NUM_CH-1:0] dtx_s_reg;
	logic power_s;

	// Reset release through two flip-flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Two-stage sampling of pins
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_sync_reg <= 2'h0;
			htx_meta_reg <= '1;
			htx_s_reg <= '1;
			dtx_meta_reg <= '1;
			dtx_s_reg <= '1;
		end else begin
			pwr_sync_reg <= {pwr_sync_reg[0], i_dut_power};
			htx_meta_reg <= i_host_tx;
			htx_s_reg <= htx_meta_reg;
			dtx_meta_reg <= i_dut_tx;
			dtx_s_reg <= dtx_meta_reg;
		end
	end
	assign power_s = pwr_sync_reg[1];

	// ----------------------------------------
	// Command buffer and mode registers
	// ----------------------------------------
	logic cmd_valid;
	logic [URS_CMD_W-1:0] cmd_data;
	logic cmd_take;
	logic [1:0] cmd_code;
	logic [1:0] cmd_ch;
	urs_mode_t mode_reg [URS_NUM_CH];
	urs_tmr_t tmr_reg;
	logic trim_req;

	urs_buf2 #(.W(URS_CMD_W)) u_buf (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_valid(i_cmd_valid),
		.i_data(i_cmd_data),
		.o_ready(o_cmd_ready),
		.o_valid(cmd_valid),
		.o_data(cmd_data),
		.i_ready(tmr_reg == URS_TMR_IDLE)
	);

	// Commands stall while a trim pulse runs
	assign cmd_take = cmd_valid && (tmr_reg == URS_TMR_IDLE);
	assign cmd_code = cmd_data[URS_CMD_MODE_LSB +: 2];
	assign cmd_ch = cmd_data[URS_CMD_CH_LSB +: 2];
	assign trim_req = cmd_take && (cmd_code == URS_CODE_TRIM);

	// Per-channel mode, changed only by a taken command
	generate
		for (genvar ch = 0; ch < URS_NUM_CH; ch++) begin : g_mode
			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n) begin
					mode_reg[ch] <= URS_MODE_RST;
				end else if (cmd_take && cmd_ch == 2'(ch)) begin
					case (cmd_code)
						URS_CODE_NORMAL: mode_reg[ch] <= URS_MODE_NORMAL;
						URS_CODE_TRIM: mode_reg[ch] <= URS_MODE_TRIM;
						URS_CODE_LOOP: mode_reg[ch] <= URS_MODE_LOOP;
						default: mode_reg[ch] <= mode_reg[ch];
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Trim pulse timer
	// ----------------------------------------
	logic sel_long_reg;
	logic [URS_CNT_W-1:0] cnt_reg;
	logic [URS_CNT_W-1:0] len_reg;

	// Pulse starts on a trim command and ends after the selected length
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_reg <= URS_TMR_IDLE;
			cnt_reg <= '0;
			len_reg <= '0;
		end else begin
			case (tmr_reg)
				URS_TMR_IDLE: begin
					cnt_reg <= '0;
					if (trim_req) begin
						tmr_reg <= URS_TMR_PULSE;
						len_reg <= sel_long_reg ? URS_CNT_W'(P_TRIM_LONG_CYC) :
							URS_CNT_W'(P_TRIM_SHORT_CYC);
					end
				end
				URS_TMR_PULSE: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == len_reg - 1'b1) begin
						tmr_reg <= URS_TMR_IDLE;
					end
				end
				default: tmr_reg <= URS_TMR_IDLE;
			endcase
		end
	end

	// Independent count of pulse cycles, used only by the length check
	logic [URS_CNT_W-1:0] chk_len_reg;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_len_reg <= '0;
		end else begin
			chk_len_reg <= (tmr_reg == URS_TMR_PULSE) ? chk_len_reg + 1'b1 : '0;
		end
	end

	// ----------------------------------------
	// Routing outputs
	// ----------------------------------------
	generate
		for (genvar ch = 0; ch < URS_NUM_CH; ch++) begin : g_route
			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n) begin
					o_host_rx[ch] <= 1'b1;
					o_dut_rx[ch] <= 1'b0;
					o_dut_rx_oe_n[ch] <= 1'b1;
				end else begin
					// Bridge receive source
					if (mode_reg[ch] == URS_MODE_LOOP) begin
						o_host_rx[ch] <= htx_s_reg[ch];
					end else if (power_s) begin
						o_host_rx[ch] <= dtx_s_reg[ch];
					end else begin
						o_host_rx[ch] <= 1'b1;
					end
					// Tested device receive pin: one source at most
					if (!power_s) begin
						o_dut_rx[ch] <= 1'b0;
						o_dut_rx_oe_n[ch] <= 1'b1;
					end else if (mode_reg[ch] == URS_MODE_NORMAL) begin
						o_dut_rx[ch] <= htx_s_reg[ch];
						o_dut_rx_oe_n[ch] <= 1'b0;
					end else if (mode_reg[ch] == URS_MODE_TRIM) begin
						o_dut_rx[ch] <= (tmr_reg == URS_TMR_PULSE);
						o_dut_rx_oe_n[ch] <= 1'b0;
					end else begin
						o_dut_rx[ch] <= 1'b0;
						o_dut_rx_oe_n[ch] <= 1'b1;
					end
				end
			end

			a_mode_onehot: assert property (@(posedge i_clk) disable iff (!rst_n)
				$onehot(mode_reg[ch])) else $error("routing mode not one-hot");
			a_normal_fwd: assert property (@(posedge i_clk) disable iff (!rst_n)
				(power_s && mode_reg[ch] == URS_MODE_NORMAL) |=>
				(!o_dut_rx_oe_n[ch] && o_dut_rx[ch] == $past(htx_s_reg[ch])))
				else $error("host tx not forwarded to device rx");
			a_dut_return: assert property (@(posedge i_clk) disable iff (!rst_n)
				(power_s && mode_reg[ch] != URS_MODE_LOOP) |=>
				(o_host_rx[ch] == $past(dtx_s_reg[ch])))
				else $error("device tx not returned to host rx");
			a_loop_path: assert property (@(posedge i_clk) disable iff (!rst_n)
				(mode_reg[ch] == URS_MODE_LOOP) |=>
				(o_host_rx[ch] == $past(htx_s_reg[ch]) && o_dut_rx_oe_n[ch]))
				else $error("loopback path wrong");
			a_power_cut: assert property (@(posedge i_clk) disable iff (!rst_n)
				!power_s |=> o_dut_rx_oe_n[ch]) else $error("device line driven without supply");
			a_trim_drive: assert property (@(posedge i_clk) disable iff (!rst_n)
				(power_s && mode_reg[ch] == URS_MODE_TRIM) |=>
				(!o_dut_rx_oe_n[ch] && o_dut_rx[ch] == ($past(tmr_reg) == URS_TMR_PULSE)))
				else $error("trim pulse not on device rx");
			a_mode_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
				!(cmd_take && cmd_ch == 2'(ch)) |=> $stable(mode_reg[ch]))
				else $error("mode changed without command");
		end
	endgenerate

	sequence s_trim_cmd;
		trim_req;
	endsequence
	sequence s_pulse_on;
		tmr_reg == URS_TMR_PULSE && cnt_reg == '0;
	endsequence
	a_trim_start: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_trim_cmd |=> s_pulse_on) else $error("trim pulse did not start");
	a_pulse_len: assert property (@(posedge i_clk) disable iff (!rst_n)
		(tmr_reg == URS_TMR_PULSE) ##1 (tmr_reg == URS_TMR_IDLE) |->
		(chk_len_reg == len_reg && (len_reg == URS_CNT_W'(P_TRIM_LONG_CYC) ||
		len_reg == URS_CNT_W'(P_TRIM_SHORT_CYC)))) else $error("trim pulse length wrong");
	a_len_value: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_trim_cmd |=> (len_reg == (($past(sel_long_reg)) ? URS_CNT_W'(P_TRIM_LONG_CYC) :
		URS_CNT_W'(P_TRIM_SHORT_CYC)))) else $error("trim length not selected");

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic apb_wr;
	logic apb_rd;
	logic [31:0] route_bits;

	assign o_pready = 1'b1;
	assign apb_wr = i_psel && i_penable && i_pwrite;
	assign apb_rd = i_psel && !i_pwrite;

	// Length select register
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_long_reg <= URS_TRIM_SEL_RST;
		end else if (apb_wr && i_paddr == URS_TRIM_CFG_OFS) begin
			sel_long_reg <= i_pwdata[URS_TRIM_SEL_LONG_BIT];
		end
	end

	// Route state readback, three bits per channel
	always_comb begin
		route_bits = '0;
		for (int ch = 0; ch < URS_NUM_CH; ch++) begin
			route_bits[ch*3 +: 3] = mode_reg[ch];
		end
	end

	// Read data and error, registered at setup
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else if (i_psel && !i_penable) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
			if (i_paddr == URS_TRIM_CFG_OFS) begin
				if (apb_rd) o_prdata[URS_TRIM_SEL_LONG_BIT] <= sel_long_reg;
			end else if (i_paddr == URS_STATUS_OFS) begin
				if (apb_rd) begin
					o_prdata[URS_ST_POWER_BIT] <= power_s;
					o_prdata[URS_ST_PULSE_BIT] <= (tmr_reg == URS_TMR_PULSE);
					o_prdata[URS_ST_PEND_BIT] <= cmd_valid;
				end
			end else if (i_paddr == URS_ROUTE_OFS) begin
				if (apb_rd) o_prdata <= route_bits;
			end else begin
				o_pslverr <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== hdl/urs_pkg.sv
`default_nettype none
package urs_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int URS_NUM_CH = 4;
	localparam int URS_CMD_W = 8;
	localparam int URS_CNT_W = 24;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint unsigned URS_CLK_HZ = 25_000_000;
	localparam longint unsigned URS_TRIM_LONG_MS = 500;
	localparam longint unsigned URS_TRIM_SHORT_MS = 300;
	localparam longint unsigned URS_TRIM_LONG_CYC = URS_TRIM_LONG_MS * URS_CLK_HZ / 1000;
	localparam longint unsigned URS_TRIM_SHORT_CYC = URS_TRIM_SHORT_MS * URS_CLK_HZ / 1000;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] URS_TRIM_CFG_OFS = 12'h000;
	localparam logic [11:0] URS_STATUS_OFS = 12'h004;
	localparam logic [11:0] URS_ROUTE_OFS = 12'h008;
	localparam int URS_TRIM_SEL_LONG_BIT = 0;
	localparam logic URS_TRIM_SEL_RST = 1'b1;
	localparam int URS_ST_POWER_BIT = 0;
	localparam int URS_ST_PULSE_BIT = 1;
	localparam int URS_ST_PEND_BIT = 2;
	// ----------------------------------------
	// Command word: [1:0] mode code, [3:2] channel
	// ----------------------------------------
	localparam int URS_CMD_MODE_LSB = 0;
	localparam int URS_CMD_CH_LSB = 2;
	localparam logic [1:0] URS_CODE_NORMAL = 2'h0;
	localparam logic [1:0] URS_CODE_TRIM = 2'h1;
	localparam logic [1:0] URS_CODE_LOOP = 2'h2;
	// Routing mode per channel, one-hot
	typedef enum logic [2:0] {
		URS_MODE_NORMAL = 3'b001,
		URS_MODE_TRIM = 3'b010,
		URS_MODE_LOOP = 3'b100
	} urs_mode_t;
	localparam urs_mode_t URS_MODE_RST = URS_MODE_NORMAL;
	// Trim pulse timer states
	typedef enum logic [1:0] {
		URS_TMR_IDLE = 2'b01,
		URS_TMR_PULSE = 2'b10
	} urs_tmr_t;
endpackage
`default_nettype wire

// ===== hdl/urs_buf2.sv
`default_nettype none
// ----------------------------------------
// Two-entry command buffer
// ----------------------------------------
module urs_buf2 #(
	parameter int W = urs_pkg::URS_CMD_W
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst_n, // Synchronised reset, active low
	input wire logic i_valid, // Fill side valid
	input wire logic [W-1:0] i_data, // Fill side data
	output logic o_ready, // Fill side ready
	output logic o_valid, // Drain side valid
	output logic [W-1:0] o_data, // Drain side data
	input wire logic i_ready // Drain side ready
);
	import urs_pkg::*;
	logic [W-1:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic push;
	logic pop;

	// Handshakes
	assign o_ready = (cnt_reg != 2'h2);
	assign o_valid = (cnt_reg != 2'h0);
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem_reg[rd_ptr_reg];

	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// ===== tb/urs_far_side.sv
`default_nettype none
// ----------------------------------------
// Far side: bridge channels and tested devices
// ----------------------------------------
module urs_far_side
	import urs_pkg::*;
(
	input wire logic i_clk, // Clock
	input wire logic [URS_NUM_CH-1:0] i_dut_rx, // Receive pin level
	input wire logic [URS_NUM_CH-1:0] i_dut_rx_oe_n, // Pin released when high
	output logic [URS_NUM_CH-1:0] o_host_tx, // Bridge transmit lines
	output logic [URS_NUM_CH-1:0] o_dut_tx, // Device transmit lines
	output logic [URS_NUM_CH-1:0] o_pin // Resolved receive pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [URS_NUM_CH-1:0] last_pin = '0;
	// Released pin floats: show a level that flips every cycle
	assign o_pin = (~i_dut_rx_oe_n & i_dut_rx) | (i_dut_rx_oe_n & ~last_pin);
	always @(posedge i_clk) begin
		last_pin <= o_pin;
	end
	// Lines idle high and change just after an edge
	initial begin
		o_host_tx = '1;
		o_dut_tx = '1;
	end
	task automatic drive(input logic [URS_NUM_CH-1:0] h, input logic [URS_NUM_CH-1:0] d);
		@(posedge i_clk);
		o_host_tx <= h;
		o_dut_tx <= d;
	endtask
endmodule
`default_nettype wire

// ===== tb/uart_route_switch_matrix_tb.sv
`default_nettype none
module uart_route_switch_matrix_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import urs_pkg::*;
	localparam int L_LONG = 20;
	localparam int L_SHORT = 12;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd, r;
	logic pready, pslverr, err, cmd_ready;
	logic cmd_valid = 1'b0;
	logic pwr = 1'b1;
	logic [7:0] cmd_data = 8'h00;
	logic [3:0] htx, hrx, dtx, drx, oe_n, pin;
	urs_mode_t md [4] = '{default: URS_MODE_RST};
	int mismatches = 0;
	int num_checks = 0;
	always #20 clk = ~clk;
	urs_switch_matrix #(.P_TRIM_LONG_CYC(L_LONG), .P_TRIM_SHORT_CYC(L_SHORT)) i_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_cmd_valid(cmd_valid),
		.i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .i_dut_power(pwr),
		.i_host_tx(htx), .o_host_rx(hrx), .i_dut_tx(dtx), .o_dut_rx(drx),
		.o_dut_rx_oe_n(oe_n));
	urs_far_side u_far (.i_clk(clk), .i_dut_rx(drx), .i_dut_rx_oe_n(oe_n),
		.o_host_tx(htx), .o_dut_tx(dtx), .o_pin(pin));
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// APB transfer held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, "read data");
		chk({31'h0, err}, {31'h0, ee}, "read error");
	endtask
	// Command word through the stream; model follows real codes only
	task automatic send(input logic [1:0] code, input int ch);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_data <= {4'h0, 2'(ch), code};
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		if (code == URS_CODE_NORMAL)
			md[ch] = URS_MODE_NORMAL;
		else if (code == URS_CODE_TRIM)
			md[ch] = URS_MODE_TRIM;
		else if (code == URS_CODE_LOOP)
			md[ch] = URS_MODE_LOOP;
	endtask
	function automatic logic [31:0] route_exp();
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int k = 0; k < 4; k++)
			v[3*k+:3] = md[k];
		return v;
	endfunction
	// Random line levels, then compare every routed output
	task automatic settle(input string m);
		logic [3:0] h, d, eh, eo, ed;
		h = 4'($urandom);
		d = 4'($urandom);
		u_far.drive(h, d);
		repeat (8) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			eo[k] = !pwr || md[k] == URS_MODE_LOOP;
			eh[k] = md[k] == URS_MODE_LOOP ? h[k] : (pwr ? d[k] : 1'b1);
			ed[k] = md[k] == URS_MODE_NORMAL ? h[k] : 1'b0;
		end
		chk({28'h0, hrx}, {28'h0, eh}, m);
		chk({28'h0, oe_n}, {28'h0, eo}, m);
		chk({28'h0, drx & ~eo}, {28'h0, ed & ~eo}, m);
		chk({28'h0, pin & ~eo}, {28'h0, ed & ~eo}, m);
	endtask
	task automatic pulse(input int ch, input int len);
		int n;
		n = 0;
		// Quiet bridge lines first so a normal-mode level is not counted as pulse
		u_far.drive(4'h0, 4'hF);
		repeat (4) @(posedge clk);
		send(URS_CODE_TRIM, ch);
		repeat (len + 20) begin
			@(posedge clk);
			n += int'(drx[ch] === 1'b1);
		end
		chk(32'(n), 32'(len), "pulse length");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int c, ch;
		void'($urandom(8));
		repeat (2) @(posedge clk);
		chk({28'h0, hrx}, 32'h0000_000F, "reset host rx");
		chk({28'h0, oe_n}, 32'h0000_000F, "reset released");
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(URS_TRIM_CFG_OFS, 32'h0000_0001, 1'b0);
		rchk(URS_ROUTE_OFS, route_exp(), 1'b0);
		apb(1'b1, URS_ROUTE_OFS, 32'hFFFF_FFFF);
		rchk(URS_ROUTE_OFS, route_exp(), 1'b0);
		rchk(12'h00C, 32'h0000_0000, 1'b1);
		settle("normal");
		for (int k = 0; k < 4; k++)
			send(URS_CODE_LOOP, k);
		rchk(URS_ROUTE_OFS, route_exp(), 1'b0);
		settle("loopback");
		for (int k = 0; k < 3; k++)
			send(URS_CODE_NORMAL, k);
		pulse(2, L_LONG);
		settle("trim");
		apb(1'b1, URS_TRIM_CFG_OFS, 32'h0000_0000);
		rchk(URS_TRIM_CFG_OFS, 32'h0000_0000, 1'b0);
		pulse(1, L_SHORT);
		apb(1'b1, URS_TRIM_CFG_OFS, 32'h0000_0001);
		// Commands wait while a pulse runs and fill the buffer
		send(URS_CODE_TRIM, 0);
		r = route_exp();
		send(URS_CODE_NORMAL, 0);
		send(URS_CODE_LOOP, 3);
		@(negedge clk);
		chk({31'h0, cmd_ready}, 32'h0000_0000, "buffer full");
		rchk(URS_STATUS_OFS, 32'h0000_0007, 1'b0);
		rchk(URS_ROUTE_OFS, r, 1'b0);
		repeat (40) @(posedge clk);
		rchk(URS_ROUTE_OFS, route_exp(), 1'b0);
		send(2'h3, 3);
		rchk(URS_ROUTE_OFS, route_exp(), 1'b0);
		pwr <= 1'b0;
		settle("no supply");
		rchk(URS_STATUS_OFS, 32'h0000_0000, 1'b0);
		pwr <= 1'b1;
		settle("supply back");
		for (int i = 0; i < 6; i++) begin
			c = $urandom_range(2);
			ch = $urandom_range(3);
			send(2'(c), ch);
			if (c == 1)
				repeat (30) @(posedge clk);
			settle("random");
			rchk(URS_ROUTE_OFS, route_exp(), 1'b0);
		end
		summarize();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
